//--- include/acsp_pin_if.sv
// Synchronised pin levels passed from the input synchroniser to the port core.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
`default_nettype none

interface acsp_pin_if;
	logic sclk_s;
	logic csn_s;
	logic sdi_s;

	modport sync_mp (output sclk_s, output csn_s, output sdi_s);
	modport core_mp (input sclk_s, input csn_s, input sdi_s);
endinterface

`default_nettype wire

//--- include/acsp_pkg.sv
// Constants, state codes and field positions of the serial configuration port.
// Assumes nothing beyond a SystemVerilog compiler; shared by the port, the synchroniser and the bench.
`default_nettype none

package acsp_pkg;

	// Register addresses
	localparam logic [12:0] ACSP_CFG_ADDR = 13'h0000;
	localparam logic [12:0] ACSP_ID_ADDR = 13'h0001;
	localparam logic [12:0] ACSP_XFER_ADDR = 13'h00ff;
	localparam logic [12:0] ACSP_FUNC_LO = 13'h0008;
	localparam logic [12:0] ACSP_FUNC_HI = 13'h003a;
	localparam int ACSP_FUNC_N = 51;

	// Values after reset, and the transfer command
	localparam logic [7:0] ACSP_CFG_RST = 8'h18;
	localparam logic [7:0] ACSP_FUNC_RST = 8'h00;
	localparam logic [7:0] ACSP_XFER_CMD = 8'h01;

	// Port configuration fields, mirrored across the nibbles
	localparam int ACSP_CFG_LSB_HI = 6;
	localparam int ACSP_CFG_LSB_LO = 1;
	localparam int ACSP_CFG_SRST_HI = 5;
	localparam int ACSP_CFG_SRST_LO = 2;

	// Instruction fields
	localparam logic [3:0] ACSP_INS_LAST = 4'hf;
	localparam int ACSP_INS_RW = 15;
	localparam int ACSP_INS_WCH = 14;
	localparam int ACSP_INS_WCL = 13;
	localparam logic [1:0] ACSP_WC_STREAM = 2'h3;
	localparam logic [2:0] ACSP_BYTE_LAST = 3'h7;

	// Frame states
	typedef enum logic [3:0] {
		ACSP_ST_IDLE = 4'b0001,
		ACSP_ST_INSTR = 4'b0010,
		ACSP_ST_DATA = 4'b0100,
		ACSP_ST_DONE = 4'b1000
	} acsp_state_e;

endpackage

`default_nettype wire

//--- rtl/acsp_port.sv
// Three-wire serial configuration port: frame engine and register store.
// Assumes the host's shift clock is far slower than ref_clk_i (4+ cycles per phase).
// How it works
// - Select low enables transfers; high pauses them
// - Sample on shift-clock rise, launch on fall
// - Frame starts after select falls, first rise
// - Select held low keeps the port streaming
// - Select high between counted bytes stalls, state kept; it ends a streaming frame
// - Select high idle: pin released, alternates enabled
// - Each frame opens with 16 instruction bits
// - Two count bits set bytes that follow
// - Data moves in whole eight-bit bytes
// - First instruction bit chooses read or write
// - Reads turn the data pin around after instruction
// - Data most significant first after reset, configurable; instruction always MSB first
// - Config holds mirrored order/reset bits, default 0x18
// - Function writes shadowed; transfer command applies them
`timescale 1ns/1ps
`default_nettype none

module acsp_port
	import acsp_pkg::*;
#(
	parameter logic [7:0] CHIP_ID = 8'h5a // Arbitrary identity value
)
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic sclk_i,
	input wire logic port_select_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_o,
	output logic lsb_first_o,
	output logic secondary_en_o,
	output logic transfer_o,
	output logic soft_reset_o,
	output logic [ACSP_FUNC_N*8-1:0] func_regs_o
);

	typedef struct packed {
		acsp_state_e st;
		logic sclk_prev;
		logic [3:0] icnt;
		logic [15:0] ins;
		logic [2:0] bcnt;
		logic [1:0] left;
		logic stream;
		logic rd;
		logic [12:0] addr;
		logic [7:0] sr;
		logic sdo;
		logic oe;
		logic sec;
		logic xfer;
		logic srst;
		logic [7:0] cfg;
		logic [ACSP_FUNC_N-1:0][7:0] shadow;
		logic [ACSP_FUNC_N-1:0][7:0] active;
	} acsp_core_s;

	localparam acsp_core_s CORE_RST = '{
		st: ACSP_ST_IDLE,
		cfg: ACSP_CFG_RST,
		shadow: {ACSP_FUNC_N{ACSP_FUNC_RST}},
		active: {ACSP_FUNC_N{ACSP_FUNC_RST}},
		sec: 1'b1,
		default: '0
	};

	acsp_pin_if pin ();

	acsp_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.clk_en_i(clk_en_i),
		.sclk_i(sclk_i),
		.port_select_n_i(port_select_n_i),
		.sdio_i(sdio_i),
		.pin(pin)
	);

	acsp_core_s q;
	acsp_core_s d;
	logic sel;
	logic rise;
	logic fall;
	logic lsb;
	logic [7:0] rdata;
	logic [7:0] wbyte;
	logic in_func;
	logic [5:0] fidx;

	// Shift-clock edges count only while selected
	assign sel = ~pin.csn_s;
	assign rise = sel & pin.sclk_s & ~q.sclk_prev;
	assign fall = sel & ~pin.sclk_s & q.sclk_prev;
	assign lsb = q.cfg[ACSP_CFG_LSB_HI] | q.cfg[ACSP_CFG_LSB_LO];

	// Function register window decode
	assign in_func = (q.addr >= ACSP_FUNC_LO) && (q.addr <= ACSP_FUNC_HI);
	assign fidx = 6'(q.addr - ACSP_FUNC_LO);

	// Readback mux; transfer bit always reads cleared
	always_comb
	begin
		rdata = 8'h00;
		if (q.addr == ACSP_CFG_ADDR)
			rdata = q.cfg;
		else if (q.addr == ACSP_ID_ADDR)
			rdata = CHIP_ID;
		else if (in_func)
			rdata = q.shadow[fidx];
	end

	// Byte being assembled, including the bit sampled now
	assign wbyte = lsb ? {pin.sdi_s, q.sr[7:1]} : {q.sr[6:0], pin.sdi_s};

	// Frame engine and register writes
	always_comb
	begin
		d = q;
		d.sclk_prev = pin.sclk_s;
		d.xfer = 1'b0;
		d.srst = 1'b0;
		case (q.st)
			ACSP_ST_IDLE:
			begin
				if (sel)
				begin
					d.st = ACSP_ST_INSTR;
					d.icnt = 4'h0;
					d.bcnt = 3'h0;
				end
			end
			ACSP_ST_INSTR:
			begin
				// Instruction always arrives read/write bit first
				if (rise)
				begin
					d.ins = {q.ins[14:0], pin.sdi_s};
					d.icnt = 4'(q.icnt + 4'h1);
					if (q.icnt == ACSP_INS_LAST)
					begin
						d.st = ACSP_ST_DATA;
						d.rd = d.ins[ACSP_INS_RW];
						d.left = {d.ins[ACSP_INS_WCH], d.ins[ACSP_INS_WCL]};
						d.stream = d.left == ACSP_WC_STREAM;
						d.addr = d.ins[12:0];
					end
				end
			end
			ACSP_ST_DATA:
			begin
				if (q.stream && !sel)
					d.st = ACSP_ST_IDLE;
				else if (rise)
				begin
					d.bcnt = 3'(q.bcnt + 3'h1);
					if (!q.rd)
						d.sr = wbyte;
					if (q.bcnt == ACSP_BYTE_LAST)
					begin
						// Whole byte done: store, then step address
						if (!q.rd)
						begin
							if (q.addr == ACSP_CFG_ADDR)
							begin
								if (wbyte[ACSP_CFG_SRST_HI] | wbyte[ACSP_CFG_SRST_LO])
								begin
									d.cfg = ACSP_CFG_RST;
									d.shadow = {ACSP_FUNC_N{ACSP_FUNC_RST}};
									d.active = {ACSP_FUNC_N{ACSP_FUNC_RST}};
									d.srst = 1'b1;
								end
								else
									d.cfg = wbyte;
							end
							else if (in_func)
								d.shadow[fidx] = wbyte;
							else if (q.addr == ACSP_XFER_ADDR && wbyte == ACSP_XFER_CMD)
								d.xfer = 1'b1;
						end
						d.addr = lsb ? 13'(q.addr + 13'h1) : 13'(q.addr - 13'h1);
						if (!q.stream)
						begin
							d.left = 2'(q.left - 2'h1);
							if (q.left == 2'h0)
								d.st = ACSP_ST_DONE;
						end
					end
				end
				else if (fall && q.rd)
				begin
					// Launch the next read bit; fetch at byte start
					if (q.bcnt == 3'h0)
					begin
						d.sdo = lsb ? rdata[0] : rdata[7];
						d.sr = lsb ? {1'b0, rdata[7:1]} : {rdata[6:0], 1'b0};
					end
					else
					begin
						d.sdo = lsb ? q.sr[0] : q.sr[7];
						d.sr = lsb ? {1'b0, q.sr[7:1]} : {q.sr[6:0], 1'b0};
					end
				end
			end
			ACSP_ST_DONE:
			begin
				if (!sel)
					d.st = ACSP_ST_IDLE;
			end
			default:
				d.st = ACSP_ST_IDLE;
		endcase
		// Transfer copies every shadow at once, bit clears itself
		if (d.xfer)
			d.active = d.shadow;
		d.oe = sel && d.st == ACSP_ST_DATA && d.rd;
		d.sec = !sel && (d.st == ACSP_ST_IDLE || d.st == ACSP_ST_DONE);
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= CORE_RST;
		else if (clk_en_i)
			q <= d;
	end

	// Outputs straight from state
	assign sdio_o = q.sdo;
	assign sdio_oe_o = q.oe;
	assign lsb_first_o = lsb;
	assign secondary_en_o = q.sec;
	assign transfer_o = q.xfer;
	assign soft_reset_o = q.srst;
	assign func_regs_o = q.active;

	// Checks on the frame engine
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_stall_high_z: assert property (clk_en_i && pin.csn_s |=> !sdio_oe_o)
		else $error("data pin driven while deselected");
	a_oe_read_only: assert property (sdio_oe_o |-> q.st == ACSP_ST_DATA && q.rd)
		else $error("data pin driven outside a read data phase");
	a_frame_start: assert property (
		clk_en_i && q.st == ACSP_ST_IDLE && !pin.csn_s |=> q.st == ACSP_ST_INSTR && q.icnt == 4'h0)
		else $error("frame did not open after select fell");
	a_instr_length: assert property (
		clk_en_i && q.st == ACSP_ST_INSTR && rise && q.icnt == 4'hf |=> q.st == ACSP_ST_DATA)
		else $error("data phase not entered after sixteen instruction bits");
	a_stall_keeps: assert property (
		clk_en_i && pin.csn_s && q.st == ACSP_ST_INSTR |=> $stable(q.ins) && $stable(q.icnt))
		else $error("instruction state lost during stall");
	a_count_end: assert property (
		clk_en_i && q.st == ACSP_ST_DATA && !q.stream && rise && q.bcnt == 3'h7
		&& q.left == 2'h0 |=> q.st == ACSP_ST_DONE)
		else $error("counted frame did not finish on its last byte");
	a_stream_stays: assert property (
		clk_en_i && q.st == ACSP_ST_DATA && q.stream && !pin.csn_s |=> q.st == ACSP_ST_DATA)
		else $error("streaming frame ended while selected");
	a_xfer_applies: assert property (clk_en_i && d.xfer |=> transfer_o && q.active == q.shadow)
		else $error("transfer did not copy shadow registers");
	a_srst_defaults: assert property ($rose(soft_reset_o) |-> q.cfg == 8'h18 && !lsb_first_o)
		else $error("soft reset did not restore port configuration");
	a_addr_step: assert property (
		clk_en_i && q.st == ACSP_ST_DATA && rise && q.bcnt == 3'h7
		|=> q.addr == ($past(lsb) ? 13'($past(q.addr) + 13'h1) : 13'($past(q.addr) - 13'h1)))
		else $error("address not stepped in the selected direction");

	// Pulses last one cycle; pin quiet in idle and done; secondary off while selected; instruction count steps
	a_xfer_pulse: assert property (clk_en_i && transfer_o |=> !transfer_o)
		else $error("transfer pulse longer than one cycle");
	a_srst_pulse: assert property (clk_en_i && soft_reset_o |=> !soft_reset_o)
		else $error("soft reset pulse longer than one cycle");
	a_done_quiet: assert property (clk_en_i && q.st == ACSP_ST_DONE |=> !sdio_oe_o)
		else $error("data pin driven after the last counted byte");
	a_idle_quiet: assert property (clk_en_i && q.st == ACSP_ST_IDLE |=> !sdio_oe_o)
		else $error("data pin driven before the instruction ended");
	a_sec_off_sel: assert property (clk_en_i && !pin.csn_s |=> !secondary_en_o)
		else $error("secondary functions on while selected");
	a_instr_count: assert property (
		clk_en_i && q.st == ACSP_ST_INSTR && rise |=> q.icnt == 4'($past(q.icnt) + 4'h1))
		else $error("instruction bit count did not advance");

	// Main scenarios reached
	c_stream_read: cover property (q.st == ACSP_ST_DATA && q.stream && q.rd && q.bcnt == 3'h7 && rise);
	c_transfer: cover property (transfer_o);
	c_stall_mid: cover property (q.st == ACSP_ST_DATA && pin.csn_s && !q.stream);
	c_lsb_mode: cover property (lsb_first_o && q.st == ACSP_ST_DONE);
	c_three_byte: cover property (q.st == ACSP_ST_DATA && !q.stream && q.left == 2'h2 && rise);

endmodule // acsp_port

`default_nettype wire

//--- rtl/acsp_sync.sv
// Two-stage synchroniser for the shift clock, select and data pins.
// Assumes the pins are asynchronous to ref_clk_i and slow against it.
`timescale 1ns/1ps
`default_nettype none

module acsp_sync
	import acsp_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic sclk_i,
	input wire logic port_select_n_i,
	input wire logic sdio_i,
	acsp_pin_if.sync_mp pin
);

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
	} acsp_sync_s;

	// Select idles high so the port starts deselected
	localparam acsp_sync_s SYNC_RST = '{s1: 3'h2, s2: 3'h2};

	acsp_sync_s q;
	acsp_sync_s d;

	// First stage feeds only the second stage
	always_comb
	begin
		d.s1 = {sdio_i, port_select_n_i, sclk_i};
		d.s2 = q.s1;
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= SYNC_RST;
		else if (clk_en_i)
			q <= d;
	end

	// Second stage drives the core
	assign pin.sclk_s = q.s2[0];
	assign pin.csn_s = q.s2[1];
	assign pin.sdi_s = q.s2[2];

endmodule // acsp_sync

`default_nettype wire

//--- verification/acsp_host_model.sv
// Host-side serial master model driving shift clock, select and data.
// Assumes ref_clk_i is the device reference clock; sdio_line_i is the resolved pin.
`timescale 1ns/1ps
`default_nettype none

module acsp_host_model
(
	input wire logic ref_clk_i,
	input wire logic sdio_line_i,
	output var logic sclk_o,
	output var logic csn_o,
	output var logic sdio_o,
	output var logic sdio_oe_o
);
	// Idle: deselected, clock low, pin released
	initial
	begin
		sclk_o = 1'b0;
		csn_o = 1'b1;
		sdio_o = 1'b0;
		sdio_oe_o = 1'b0;
	end

	// Wait n falling reference edges
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	// Move select with quiet margins around it
	task automatic sel(input logic v);
		tick(4);
		csn_o = v;
		tick(4);
	endtask

	// One shift-clock period; data held only around the rise
	task automatic bit_io(input logic b, input logic drv, output logic r);
		sdio_o = b;
		sdio_oe_o = drv;
		tick(4);
		r = sdio_line_i;
		sclk_o = 1'b1;
		tick(3);
		sdio_oe_o = 1'b0; // Release after the hold time
		tick(1);
		sclk_o = 1'b0;
	endtask
endmodule // acsp_host_model

`default_nettype wire

//--- verification/adc_config_serial_port_tb.sv
// Self-checking bench for the serial configuration port.
// Assumes acsp_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module adc_config_serial_port_tb
	import acsp_pkg::*;
;
	localparam logic [7:0] TB_ID = 8'h3c; // Arbitrary identity value
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic sclk, csn, h_d, h_oe, d_o, d_oe, lsb_o, sec_o, xf_o, sr_o, line;
	logic last_q = 1'b0;
	logic clk_en = 1'b1;
	logic [ACSP_FUNC_N*8-1:0] func;
	logic [7:0] wbuf [0:3];
	logic [7:0] rbuf [0:3];
	logic [7:0] xf_cnt = 8'h00;
	logic [7:0] sr_cnt = 8'h00;
	int num_errors = 0;
	int checks_done = 0;

	// 50 MHz reference clock
	always #10 ref_clk_i = ~ref_clk_i;

	// Resolved data pin; undriven it toggles
	assign line = d_oe ? d_o : (h_oe ? h_d : ~last_q);
	always @(posedge ref_clk_i) last_q <= line;

	// Count one-cycle pulses, sampled where settled
	always @(negedge ref_clk_i)
	begin
		if (xf_o === 1'b1) xf_cnt <= xf_cnt + 8'h01;
		if (sr_o === 1'b1) sr_cnt <= sr_cnt + 8'h01;
	end

	acsp_port #(.CHIP_ID(TB_ID)) u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en),
		.sclk_i(sclk), .port_select_n_i(csn), .sdio_i(line), .sdio_o(d_o), .sdio_oe_o(d_oe),
		.lsb_first_o(lsb_o), .secondary_en_o(sec_o), .transfer_o(xf_o), .soft_reset_o(sr_o),
		.func_regs_o(func));

	acsp_host_model u_host (.ref_clk_i(ref_clk_i), .sdio_line_i(line), .sclk_o(sclk),
		.csn_o(csn), .sdio_o(h_d), .sdio_oe_o(h_oe));

	// Byte compare
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One data byte in the chosen order
	task automatic byte_io(input logic [7:0] d, input logic lsb, input logic drv,
		output logic [7:0] r);
		int k;
		for (int i = 0; i < 8; i++)
		begin
			k = lsb ? i : 7 - i;
			u_host.bit_io(d[k], drv, r[k]);
		end
	endtask

	// Whole frame: instruction MSB first, then n bytes, optional stalls
	task automatic frame(input logic rd, input logic [1:0] wc, input logic [12:0] a,
		input int n, input logic lsb, input logic stall);
		logic [15:0] ins;
		logic r;
		ins = {rd, wc, a};
		u_host.sel(1'b0);
		for (int i = 15; i >= 0; i--) u_host.bit_io(ins[i], 1'b1, r);
		chk8({7'h00, d_oe}, {7'h00, rd});
		chk8({7'h00, sec_o}, 8'h00);
		for (int k = 0; k < n; k++)
		begin
			if (stall && k > 0) u_host.sel(1'b1);
			if (stall && k > 0) u_host.sel(1'b0);
			byte_io(wbuf[k], lsb, !rd, rbuf[k]);
		end
		u_host.sel(1'b1);
		u_host.tick(2);
		chk8({6'h00, d_oe, sec_o}, 8'h01);
	endtask

	// Issue the transfer command and check one pulse
	task automatic apply(input logic lsb);
		logic [7:0] c;
		c = xf_cnt;
		wbuf[0] = ACSP_XFER_CMD;
		frame(1'b0, 2'h0, ACSP_XFER_ADDR, 1, lsb, 1'b0);
		chk8(xf_cnt, c + 8'h01);
	endtask

	task automatic t_reset();
		chk8({5'h00, sec_o, lsb_o, d_oe}, 8'h04);
		chk8(func[7:0], ACSP_FUNC_RST);
		$display("t_reset done");
	endtask

	// Clock enable low: select activity must go unseen
	task automatic t_freeze();
		clk_en = 1'b0;
		u_host.sel(1'b0);
		chk8({7'h00, sec_o}, 8'h01);
		u_host.sel(1'b1);
		clk_en = 1'b1;
		u_host.tick(4);
		chk8({7'h00, sec_o}, 8'h01);
		$display("t_freeze done");
	endtask

	task automatic t_read();
		frame(1'b1, 2'h0, ACSP_ID_ADDR, 1, 1'b0, 1'b0);
		chk8(rbuf[0], TB_ID);
		frame(1'b1, 2'h0, ACSP_CFG_ADDR, 1, 1'b0, 1'b0);
		chk8(rbuf[0], ACSP_CFG_RST);
		$display("t_read done");
	endtask

	task automatic t_write();
		wbuf[0] = 8'h20;
		frame(1'b0, 2'h0, ACSP_FUNC_LO, 1, 1'b0, 1'b0);
		chk8(func[7:0], 8'h00);
		apply(1'b0);
		chk8(func[7:0], 8'h20);
		$display("t_write done");
	endtask

	task automatic t_stall();
		wbuf[0] = 8'ha5;
		wbuf[1] = 8'h5a;
		frame(1'b0, 2'h1, 13'h000a, 2, 1'b0, 1'b1);
		apply(1'b0);
		chk8(func[23:16], 8'ha5);
		chk8(func[15:8], 8'h5a);
		frame(1'b1, 2'h2, 13'h000a, 3, 1'b0, 1'b1);
		chk8(rbuf[0], 8'ha5);
		chk8(rbuf[1], 8'h5a);
		chk8(rbuf[2], 8'h20);
		$display("t_stall done");
	endtask

	task automatic t_stream_lsb();
		logic [7:0] c;
		wbuf[0] = 8'h42;
		frame(1'b0, 2'h0, ACSP_CFG_ADDR, 1, 1'b0, 1'b0);
		chk8({7'h00, lsb_o}, 8'h01);
		wbuf[0] = 8'h11;
		wbuf[1] = 8'h22;
		wbuf[2] = 8'h33;
		wbuf[3] = 8'hc4;
		frame(1'b0, 2'h3, 13'h0010, 4, 1'b1, 1'b0);
		apply(1'b1);
		chk8(func[71:64], 8'h11);
		chk8(func[95:88], 8'hc4);
		frame(1'b1, 2'h3, 13'h0011, 2, 1'b1, 1'b0);
		chk8(rbuf[0], 8'h22);
		chk8(rbuf[1], 8'h33);
		c = sr_cnt;
		wbuf[0] = 8'h24;
		frame(1'b0, 2'h0, ACSP_CFG_ADDR, 1, 1'b1, 1'b0);
		chk8(sr_cnt, c + 8'h01);
		chk8({7'h00, lsb_o}, 8'h00);
		chk8(func[71:64], ACSP_FUNC_RST);
		$display("t_stream_lsb done");
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		@(negedge ref_clk_i);
		t_reset();
		t_freeze();
		t_read();
		t_write();
		t_stall();
		t_stream_lsb();
		end_of_test();
	end

	// Watchdog against a hang
	initial
	begin
		repeat (90000) @(posedge ref_clk_i);
		num_errors++;
		end_of_test();
	end
endmodule // adc_config_serial_port_tb

`default_nettype wire
